/* File: design/frs_top.sv */
// frequency reference shaper: presets, jog, skip bands, direction, hysteresis, droop
`timescale 1ns/1ps
`include "frs_defines.svh"
// Notes on behaviour
// R1 - two select inputs choose ramp set 1 to 4 in binary order
// R2 - both select inputs off uses ramp set 1
// R3 - jog ramps to jog frequency with its own acc and dec times
// R4 - jog request accepted from keypad, terminal or host
// R5 - fifteen preset references, each 0 to 600.0 Hz
// R6 - all preset terminals off selects main frequency source
// R7 - preset terminals form binary code, terminal 1 least significant
// R8 - run and stop come from command source, not preset terminals
// R9 - up to three skip bands keep steady output out of them
// R10 - reference inside a band clamps to the nearer band edge
// R11 - reversal ramps to zero, waits dead time, then runs new way
// R12 - reverse prohibit forces forward; else direction input selects
// R13 - programmed running ignores reverse prohibit
// R14 - traverse mode refuses direction change while running
// R15 - carrier frequency settable from 2.0 to 12.0 kHz
// R16 - large motors above 37 kW should use 2 kHz carrier
// R17 - after run, hold zero until reference reaches upper start level
// R18 - once running, stop only when reference reaches lower stop level
// R19 - output reduced with load by up to configured droop
// R20 - droop scales linearly, full droop at rated load
module frs_top
  import frs_pkg::*;
#(
  parameter int TICK_CYCLES = `FRS_MS_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire frs_pkg::frs_wb_req_s wb_req,
  input  wire logic              ramp_select_in0,
  input  wire logic              ramp_select_in1,
  input  wire logic [3:0]        preset_sel_in,
  input  wire logic [3:0]        preset_assigned,
  input  wire logic              direction_in,
  input  wire frs_pkg::frs_jog_src_s jog_req,
  input  wire logic [15:0]       analog_ref_in1,
  input  wire logic [15:0]       load_level,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  output logic [15:0]            out_freq_q,
  output logic                   out_reverse_q,
  output logic                   running_q,
  output logic [15:0]            carrier_freq_q
);
  import frs_pkg::*;

  logic [15:0] preset_q [15];
  logic [15:0] acc_q [4];
  logic [15:0] dec_q [4];
  logic [15:0] skip_q [3];
  logic [6:0]  ctrl_q;
  logic [15:0] main_freq_source_sel_q;
  logic [15:0] jog_freq_setting_q;
  logic [15:0] jog_acc_q;
  logic [15:0] jog_dec_q;
  logic [15:0] skip_band_width_q;
  logic [15:0] zero_freq_threshold_q;
  logic [15:0] zero_freq_hysteresis_q;
  logic [15:0] load_droop_q;
  logic [15:0] dead_time_q;
  logic [31:0] dead_cnt_q;
  frs_state_e  state_q;
  logic        dir_q;
  logic [15:0] ramp_freq;
  logic [15:0] target;
  logic [15:0] ref_sel;
  logic [15:0] ref_skip;
  logic [15:0] act_acc;
  logic [15:0] act_dec;
  logic        jog_active;
  logic        want_rev;
  logic [3:0]  preset_code;
  logic [15:0] upper_start_level;
  logic [15:0] lower_stop_level;
  logic [15:0] droop_amt;
  logic        wr;
  logic [31:0] rd_dat;

  function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v[15:0] < lo || v[31:16] != 16'h0) begin
      clamp16 = (v[31:16] != 16'h0) ? hi : lo;
    end else if (v[15:0] > hi) begin
      clamp16 = hi;
    end else begin
      clamp16 = v[15:0];
    end
  endfunction

  assign wr = wb_req.cyc && wb_req.stb && wb_req.we && !wb_ack_o;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q                 <= 7'h00;
      main_freq_source_sel_q <= 16'h0;
      jog_freq_setting_q     <= `FRS_RESET_JOG_FREQ;
      jog_acc_q              <= `FRS_RESET_JOG_TIME;
      jog_dec_q              <= `FRS_RESET_JOG_TIME;
      skip_band_width_q      <= 16'h0;
      zero_freq_threshold_q  <= 16'h0;
      zero_freq_hysteresis_q <= 16'h0;
      load_droop_q           <= 16'h0;
      carrier_freq_q         <= `FRS_RESET_CARRIER;
      dead_time_q            <= 16'h0;
      for (int i = 0; i < 15; i++) preset_q[i] <= 16'h0;
      for (int i = 0; i < 4; i++) begin
        acc_q[i] <= `FRS_RESET_RAMP;
        dec_q[i] <= `FRS_RESET_RAMP;
      end
      for (int i = 0; i < 3; i++) skip_q[i] <= 16'h0;
    end else if (wr && wb_req.sel[0]) begin
      unique case (wb_req.adr)
        `FRS_REG_CTRL:      ctrl_q <= wb_req.dat[6:0];
        `FRS_REG_MAIN_FREQ:
          main_freq_source_sel_q <= clamp16(wb_req.dat, 16'h0, `FRS_FREQ_MAX);
        `FRS_REG_JOG_FREQ: // [R3]
          jog_freq_setting_q <= clamp16(wb_req.dat, `FRS_JOG_FREQ_MIN, `FRS_JOG_FREQ_MAX);
        `FRS_REG_JOG_ACC:
          jog_acc_q <= clamp16(wb_req.dat, `FRS_JOG_TIME_MIN, `FRS_JOG_TIME_MAX); // [R3]
        `FRS_REG_JOG_DEC:
          jog_dec_q <= clamp16(wb_req.dat, `FRS_JOG_TIME_MIN, `FRS_JOG_TIME_MAX); // [R3]
        `FRS_REG_SKIP_WIDTH:
          skip_band_width_q <= clamp16(wb_req.dat, 16'h0, `FRS_SKIP_WIDTH_MAX); // [R9]
        `FRS_REG_ZERO_THR:
          zero_freq_threshold_q <= clamp16(wb_req.dat, 16'h0, `FRS_FREQ_MAX);
        `FRS_REG_ZERO_HYS:
          zero_freq_hysteresis_q <= clamp16(wb_req.dat, 16'h0, `FRS_FREQ_MAX);
        `FRS_REG_DROOP:
          load_droop_q <= clamp16(wb_req.dat, 16'h0, `FRS_DROOP_MAX); // [R19]
        `FRS_REG_CARRIER:
          carrier_freq_q <= clamp16(wb_req.dat, `FRS_CARRIER_MIN, `FRS_CARRIER_MAX); // [R15]
        `FRS_REG_DEAD_TIME: dead_time_q <= wb_req.dat[15:0];
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (wb_req.adr == `FRS_REG_ACC_BASE + 8'(4 * i))
              acc_q[i] <= clamp16(wb_req.dat, `FRS_RAMP_TIME_MIN, `FRS_RAMP_TIME_MAX);
            if (wb_req.adr == `FRS_REG_DEC_BASE + 8'(4 * i))
              dec_q[i] <= clamp16(wb_req.dat, `FRS_RAMP_TIME_MIN, `FRS_RAMP_TIME_MAX);
          end
          for (int i = 0; i < 3; i++) begin
            if (wb_req.adr == `FRS_REG_SKIP_BASE + 8'(4 * i))
              skip_q[i] <= clamp16(wb_req.dat, 16'h0, `FRS_FREQ_MAX); // [R9]
          end
          for (int i = 0; i < 15; i++) begin
            if (wb_req.adr == `FRS_REG_PRESET_BASE + 8'(4 * i))
              preset_q[i] <= clamp16(wb_req.dat, 16'h0, `FRS_FREQ_MAX); // [R5]
          end
        end
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_dat = 32'h0;
    unique case (wb_req.adr)
      `FRS_REG_CTRL:       rd_dat = {25'h0, ctrl_q};
      `FRS_REG_STATUS:     rd_dat = {27'h0, dir_q, running_q, state_q};
      `FRS_REG_OUT_FREQ:   rd_dat = {16'h0, out_freq_q};
      `FRS_REG_MAIN_FREQ:  rd_dat = {16'h0, main_freq_source_sel_q};
      `FRS_REG_JOG_FREQ:   rd_dat = {16'h0, jog_freq_setting_q};
      `FRS_REG_JOG_ACC:    rd_dat = {16'h0, jog_acc_q};
      `FRS_REG_JOG_DEC:    rd_dat = {16'h0, jog_dec_q};
      `FRS_REG_SKIP_WIDTH: rd_dat = {16'h0, skip_band_width_q};
      `FRS_REG_ZERO_THR:   rd_dat = {16'h0, zero_freq_threshold_q};
      `FRS_REG_ZERO_HYS:   rd_dat = {16'h0, zero_freq_hysteresis_q};
      `FRS_REG_DROOP:      rd_dat = {16'h0, load_droop_q};
      `FRS_REG_CARRIER:    rd_dat = {16'h0, carrier_freq_q};
      `FRS_REG_DEAD_TIME:  rd_dat = {16'h0, dead_time_q};
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (wb_req.adr == `FRS_REG_ACC_BASE + 8'(4 * i)) rd_dat = {16'h0, acc_q[i]};
          if (wb_req.adr == `FRS_REG_DEC_BASE + 8'(4 * i)) rd_dat = {16'h0, dec_q[i]};
        end
        for (int i = 0; i < 3; i++) begin
          if (wb_req.adr == `FRS_REG_SKIP_BASE + 8'(4 * i)) rd_dat = {16'h0, skip_q[i]};
        end
        for (int i = 0; i < 15; i++) begin
          if (wb_req.adr == `FRS_REG_PRESET_BASE + 8'(4 * i)) rd_dat = {16'h0, preset_q[i]};
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      // ack drops after one cycle so a request still held is not taken twice
      wb_ack_o <= wb_req.cyc && wb_req.stb && !wb_ack_o;
      wb_dat_o <= (wb_req.cyc && wb_req.stb && !wb_req.we) ? rd_dat : 32'h0;
    end
  end

  // ramp set from the two select inputs, binary order
  always_comb begin
    logic [1:0] rs;
    rs = {ramp_select_in1, ramp_select_in0}; // [R1] [R2]
    act_acc = jog_active ? jog_acc_q : acc_q[rs]; // [R3]
    act_dec = jog_active ? jog_dec_q : dec_q[rs];
  end

  assign jog_active  = ctrl_q[`FRS_CTRL_JOG] &&
                       (jog_req.keypad || jog_req.terminal || jog_req.host); // [R4]
  assign preset_code = preset_sel_in & preset_assigned; // [R7]

  // reference: jog, preset table or main source
  always_comb begin
    if (jog_active) begin
      ref_sel = jog_freq_setting_q; // [R3]
    end else if (preset_code == 4'h0) begin
      ref_sel = main_freq_source_sel_q; // [R6]
    end else begin
      ref_sel = preset_q[preset_code - 4'h1]; // [R7]
    end
  end

  // skip bands clamp to the nearer edge
  always_comb begin
    logic [16:0] lo;
    logic [16:0] hi;
    logic [15:0] half;
    lo = 17'h0;
    hi = 17'h0;
    half = skip_band_width_q >> 1;
    ref_skip = ref_sel;
    // bands are applied in order, so an edge pushed into a later band moves again
    for (int i = 0; i < 3; i++) begin
      lo = (skip_q[i] > half) ? {1'b0, skip_q[i] - half} : 17'h0;
      hi = {1'b0, skip_q[i]} + {1'b0, half};
      if (half != 16'h0 && {1'b0, ref_skip} > lo && {1'b0, ref_skip} < hi) begin // [R9]
        ref_skip = (ref_skip >= skip_q[i]) ? 16'(hi) : 16'(lo); // [R10]
      end
    end
  end

  assign upper_start_level = 16'(({1'b0, zero_freq_threshold_q} +
                                  {1'b0, zero_freq_hysteresis_q} > 17'd65535) ? 17'd65535 :
                                 {1'b0, zero_freq_threshold_q} + {1'b0, zero_freq_hysteresis_q});
  assign lower_stop_level  = zero_freq_threshold_q;

  // requested direction
  always_comb begin
    if (ctrl_q[`FRS_CTRL_PROGRAM]) begin
      want_rev = ctrl_q[`FRS_CTRL_PROG_REV]; // [R13]
    end else if (ctrl_q[`FRS_CTRL_REV_PROHIB]) begin
      want_rev = 1'b0; // [R12]
    end else begin
      want_rev = direction_in; // [R12]
    end
  end

  // run sequencer; run comes from the control register run bit or an active jog request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= FRS_IDLE;
      dir_q      <= 1'b0;
      dead_cnt_q <= 32'h0;
    end else begin
      unique case (state_q)
        FRS_IDLE: begin
          if (ctrl_q[`FRS_CTRL_RUN] || jog_active) begin // [R8]
            dir_q   <= want_rev;
            state_q <= FRS_WAIT_START;
          end
        end
        FRS_WAIT_START: begin
          if (!(ctrl_q[`FRS_CTRL_RUN] || jog_active)) state_q <= FRS_IDLE;
          else if (jog_active || !ctrl_q[`FRS_CTRL_ZERO_HYS_EN] ||
                   analog_ref_in1 >= upper_start_level) state_q <= FRS_RUN; // [R17]
        end
        FRS_RUN: begin
          if (!(ctrl_q[`FRS_CTRL_RUN] || jog_active)) begin
            state_q <= FRS_TO_ZERO;
          end else if (ctrl_q[`FRS_CTRL_ZERO_HYS_EN] && !jog_active &&
                       analog_ref_in1 <= lower_stop_level) begin
            state_q <= FRS_TO_ZERO; // [R18]
          end else if (want_rev != dir_q && !ctrl_q[`FRS_CTRL_TRAVERSE]) begin // [R14]
            state_q <= FRS_TO_ZERO; // [R11]
          end
        end
        FRS_TO_ZERO: begin
          // direction only changes once the output is at zero
          if (ramp_freq == 16'h0) begin
            dead_cnt_q <= 32'h0;
            state_q    <= (want_rev != dir_q && (ctrl_q[`FRS_CTRL_RUN] || jog_active))
                          ? FRS_DEAD : FRS_IDLE;
          end
        end
        FRS_DEAD: begin
          dead_cnt_q <= dead_cnt_q + 32'h1;
          // dead time in 0.1 s units
          if (dead_cnt_q >= 32'(dead_time_q) * 32'(TICK_CYCLES) * 32'd100) begin // [R11]
            dir_q   <= want_rev;
            state_q <= FRS_WAIT_START;
          end
        end
        // codes past the dead state are unused; fall back to idle
        default: state_q <= FRS_IDLE;
      endcase
    end
  end

  assign target = (state_q == FRS_RUN) ? ref_skip : 16'h0;

  frs_ramp #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_ramp (
    .clk      (clk),
    .rst_b    (rst_b),
    .target   (target),
    .acc_time (act_acc),
    .dec_time (act_dec),
    .freq_q   (ramp_freq)
  );

  // droop proportional to load, full value at rated load
  always_comb begin
    logic [31:0] prod;
    logic [15:0] ld;
    // load above rated counts as rated, so droop never exceeds its setting
    ld = (load_level > `FRS_LOAD_RATED) ? `FRS_LOAD_RATED : load_level;
    prod = 32'(load_droop_q) * 32'(ld) / 32'(`FRS_LOAD_RATED); // [R20]
    droop_amt = prod[15:0];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_freq_q    <= 16'h0;
      out_reverse_q <= 1'b0;
      running_q     <= 1'b0;
    end else begin
      out_freq_q    <= (ramp_freq > droop_amt) ? ramp_freq - droop_amt : 16'h0; // [R19]
      out_reverse_q <= dir_q;
      running_q     <= (state_q == FRS_RUN) || (ramp_freq != 16'h0);
    end
  end
endmodule

/* File: design/frs_defines.svh */
// constants for the frequency reference shaper
`ifndef FRS_DEFINES_SVH
`define FRS_DEFINES_SVH
`define FRS_CLK_HZ           10000000
`define FRS_MS_CYCLES        (`FRS_CLK_HZ / 1000)
`define FRS_FREQ_MAX         16'd6000
`define FRS_JOG_FREQ_MIN     16'd50
`define FRS_JOG_FREQ_MAX     16'd6000
`define FRS_JOG_TIME_MIN     16'd1
`define FRS_JOG_TIME_MAX     16'd200
`define FRS_RAMP_TIME_MIN    16'd1
`define FRS_RAMP_TIME_MAX    16'd36000
`define FRS_SKIP_WIDTH_MAX   16'd2000
`define FRS_CARRIER_MIN      16'd20
`define FRS_CARRIER_MAX      16'd120
`define FRS_DROOP_MAX        16'd1000
`define FRS_LOAD_RATED       16'd1000
`define FRS_REG_CTRL         8'h00
`define FRS_REG_STATUS       8'h04
`define FRS_REG_OUT_FREQ     8'h08
`define FRS_REG_MAIN_FREQ    8'h0c
`define FRS_REG_JOG_FREQ     8'h10
`define FRS_REG_JOG_ACC      8'h14
`define FRS_REG_JOG_DEC      8'h18
`define FRS_REG_SKIP_WIDTH   8'h1c
`define FRS_REG_ZERO_THR     8'h20
`define FRS_REG_ZERO_HYS     8'h24
`define FRS_REG_DROOP        8'h28
`define FRS_REG_CARRIER      8'h2c
`define FRS_REG_DEAD_TIME    8'h30
`define FRS_REG_ACC_BASE     8'h40
`define FRS_REG_DEC_BASE     8'h50
`define FRS_REG_SKIP_BASE    8'h60
`define FRS_REG_PRESET_BASE  8'h80
`define FRS_CTRL_RUN         0
`define FRS_CTRL_REV_PROHIB  1
`define FRS_CTRL_TRAVERSE    2
`define FRS_CTRL_PROGRAM     3
`define FRS_CTRL_PROG_REV    4
`define FRS_CTRL_ZERO_HYS_EN 5
`define FRS_CTRL_JOG         6
`define FRS_RESET_RAMP       16'd100
`define FRS_RESET_JOG_TIME   16'd60
`define FRS_RESET_JOG_FREQ   16'd500
`define FRS_RESET_CARRIER    16'd80
`endif

/* File: design/frs_pkg.sv */
// types for the frequency reference shaper
package frs_pkg;
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } frs_wb_req_s;
  typedef struct packed {
    logic        keypad;
    logic        terminal;
    logic        host;
  } frs_jog_src_s;
  typedef enum logic [2:0] {
    FRS_IDLE, FRS_WAIT_START, FRS_RUN, FRS_TO_ZERO, FRS_DEAD
  } frs_state_e;
endpackage

/* File: design/frs_ramp.sv */
// linear ramp generator stepping an output toward a target
`timescale 1ns/1ps
module frs_ramp #(
  parameter int TICK_CYCLES = 10000
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] target,
  input  wire logic [15:0] acc_time,
  input  wire logic [15:0] dec_time,
  output logic      [15:0] freq_q
);
  logic [31:0] tick_cnt_q;
  logic [31:0] acc_q;
  logic        tick;
  logic [15:0] time_sel;
  logic [31:0] step;
  logic [31:0] sum;
  logic [15:0] inc;

  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
  assign time_sel = (target > freq_q) ? acc_time : dec_time;
  // full scale per time unit (0.1 s = 100 ticks of 1 ms)
  assign step = (time_sel == 16'h0000) ? 32'h0000_ffff : 32'h0000_ffff / 32'(time_sel);
  assign sum = acc_q + (step * 32'd6000) / 32'd100;
  assign inc = sum[31:16];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  // fractional accumulator: 6000 * 65536 / 100 per step in frac units
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q  <= 32'h0;
      freq_q <= 16'h0;
    end else if (tick) begin
      if (target == freq_q) begin
        acc_q <= 32'h0;
      end else begin
        acc_q <= {16'h0, sum[15:0]};
        if (target > freq_q) begin
          freq_q <= (target - freq_q > inc) ? freq_q + inc : target;
        end else begin
          freq_q <= (freq_q - target > inc) ? freq_q - inc : target;
        end
      end
    end
  end
endmodule

/* File: testbench/frs_panel_model.sv */
// terminal, keypad and host model driving the shaper's control inputs
`timescale 1ns/1ps
module frs_panel_model
  import frs_pkg::*;
#(
  parameter int MOTOR_KW = 45
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [13:0]       cmd,
  output logic [1:0]             ramp_sel,
  output logic [3:0]             preset_sel,
  output logic [3:0]             assigned,
  output logic                   dir,
  output frs_pkg::frs_jog_src_s  jog,
  output logic [15:0]            carrier_pick
);
  // contacts settle one cycle after the bench asks for them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {jog, dir, assigned, preset_sel, ramp_sel} <= 14'h0000;
    end else begin
      {jog, dir, assigned, preset_sel, ramp_sel} <= cmd;
    end
  end
  // large motors get the lowest carrier
  assign carrier_pick = (MOTOR_KW > 37) ? 16'h0014 : 16'h0050;
endmodule

/* File: testbench/frs_top_monitor.sv */
// port checker for the frequency reference shaper
`timescale 1ns/1ps
module frs_top_monitor
  import frs_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire frs_pkg::frs_wb_req_s wb_req,
  input wire logic [15:0]          analog_ref_in1,
  input wire logic                 wb_ack_o,
  input wire logic [15:0]          out_freq_q,
  input wire logic                 out_reverse_q,
  input wire logic                 running_q,
  input wire logic [15:0]          carrier_freq_q
);
  logic [7:0]  ctrl_q;
  logic [15:0] thr_q;
  logic [15:0] hys_q;
  logic        wr_take;
  assign wr_take = wb_ack_o && wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel[0];
  // shadow copies of control, threshold and hysteresis
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= 8'h00;
      thr_q <= 16'h0000;
      hys_q <= 16'h0000;
    end else if (wr_take) begin
      if (wb_req.adr == 8'h00) ctrl_q <= wb_req.dat[7:0];
      if (wb_req.adr == 8'h20) thr_q <= wb_req.dat[15:0];
      if (wb_req.adr == 8'h24) hys_q <= wb_req.dat[15:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    wb_req.cyc && wb_req.stb && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_PULSE: assert property (s_take |=> s_pulse)
    else $error("bus ack not a single pulse one cycle after request");
  AST_CARRIER_RANGE: assert property (carrier_freq_q inside {[16'h0014:16'h0078]})
    else $error("carrier outside its range");
  AST_FREQ_MAX: assert property (out_freq_q <= 16'h1770)
    else $error("output frequency above full scale");
  AST_REV_AT_ZERO: assert property (!$stable(out_reverse_q) |-> out_freq_q == 16'h0000)
    else $error("direction changed with nonzero output");
  AST_REV_PROHIB: assert property (ctrl_q[1] && !ctrl_q[3] |-> !$rose(out_reverse_q))
    else $error("reverse started while prohibited");
  AST_TRAVERSE: assert property (ctrl_q[2] && $past(running_q) && running_q
      |-> $stable(out_reverse_q))
    else $error("direction changed while running in traverse");
  AST_HOLD_ZERO: assert property (ctrl_q[5] && !ctrl_q[6] && out_freq_q == 16'h0000
      && analog_ref_in1 < thr_q + hys_q |=> out_freq_q == 16'h0000)
    else $error("output left zero below the start level");
  AST_KEEP_RUN: assert property (ctrl_q[0] && ctrl_q[5] && !ctrl_q[6]
      && out_freq_q > 16'h0064 && analog_ref_in1 > thr_q |=> out_freq_q != 16'h0000)
    else $error("stopped above the stop level");
endmodule
bind frs_top frs_top_monitor u_mon (.clk(clk), .rst_b(rst_b), .wb_req(wb_req),
  .analog_ref_in1(analog_ref_in1), .wb_ack_o(wb_ack_o), .out_freq_q(out_freq_q),
  .out_reverse_q(out_reverse_q), .running_q(running_q), .carrier_freq_q(carrier_freq_q));

/* File: testbench/frs_top_bench.sv */
// self-checking bench for the frequency reference shaper
`timescale 1ns/1ps
module frs_top_bench;
  import frs_pkg::*;
  localparam int TICK = 2;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  frs_wb_req_s  wb_req = '0;
  logic [13:0]  cmd = 14'h0000;
  logic [15:0]  analog = 16'h0000;
  logic [15:0]  load = 16'h0000;
  logic [1:0]   rsel;
  logic [3:0]   psel;
  logic [3:0]   pasg;
  logic         dir;
  frs_jog_src_s jog;
  logic [15:0]  cpick;
  logic [31:0]  wb_dat_o;
  logic         wb_ack_o;
  logic [15:0]  out_freq_q;
  logic         out_reverse_q;
  logic         running_q;
  logic [15:0]  carrier_freq_q;
  logic [31:0]  rd;
  logic [15:0]  preset [1:15];
  int           num_errors = 0;
  int           n_compared = 0;
  integer       seed = 14515;
  int           c;
  int           z;
  int           e;
  int           tbl [5][2] = '{'{3050, 3100}, '{2950, 2900}, '{3000, 3100}, '{4099, 4100},
                               '{5000, 5100}};
  always #50 clk = ~clk;
  frs_panel_model u_panel (.clk(clk), .rst_b(rst_b), .cmd(cmd), .ramp_sel(rsel),
    .preset_sel(psel), .assigned(pasg), .dir(dir), .jog(jog), .carrier_pick(cpick));
  frs_top #(.TICK_CYCLES(TICK)) uut (.clk(clk), .rst_b(rst_b), .wb_req(wb_req),
    .ramp_select_in0(rsel[0]), .ramp_select_in1(rsel[1]), .preset_sel_in(psel),
    .preset_assigned(pasg), .direction_in(dir), .jog_req(jog), .analog_ref_in1(analog),
    .load_level(load), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .out_freq_q(out_freq_q),
    .out_reverse_q(out_reverse_q), .running_q(running_q), .carrier_freq_q(carrier_freq_q));
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got,
                       input logic [31:0] tol);
    n_compared++;
    if (^got === 1'bx || got > exp + tol || got + tol < exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // one classic cycle: hold until ack is sampled, then one idle cycle
  task automatic wb(input logic [7:0] a, input int d, input logic w);
    wb_req <= '{adr: a, dat: 32'(d), sel: 4'hf, we: w, cyc: 1'b1, stb: 1'b1};
    @(posedge clk);
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk);
    end
    rd = wb_dat_o;
    wb_req <= '0;
    @(posedge clk);
  endtask
  task automatic term(input int r, input int p, input int a, input int d, input int j);
    cmd <= {3'(j), 1'(d), 4'(a), 4'(p), 2'(r)};
    @(posedge clk);
  endtask
  task automatic wait_freq(input int t, input int lim);
    c = 0;
    while (out_freq_q !== 16'(t) && c < lim) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic wait_dir(input logic t, input int lim);
    c = 0;
    z = 0;
    while (out_reverse_q !== t && c < lim) begin
      @(posedge clk);
      c++;
      if (out_freq_q === 16'h0000) z++;
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial begin
    for (int i = 1; i <= 15; i++) preset[i] = 16'($unsigned($random(seed)) % 6001);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    wb(8'h2c, 0, 0);
    check("carrier reset", 80, rd, 0);
    wb(8'h2c, 10, 1);
    check("carrier low clamp", 20, carrier_freq_q, 0);
    wb(8'h2c, 200, 1);
    check("carrier high clamp", 120, carrier_freq_q, 0);
    wb(8'h2c, cpick, 1);
    check("carrier chosen", cpick, carrier_freq_q, 0);
    wb(8'hfc, 0, 0);
    check("unmapped read", 0, rd, 0);
    $display("registers done");
    for (int k = 0; k < 4; k++) begin
      wb(8'h40 + 8'(4 * k), k + 1, 1);
      wb(8'h50 + 8'(4 * k), 1, 1);
    end
    wb(8'h0c, 6000, 1);
    for (int k = 0; k < 4; k++) begin
      term(k, 0, 0, 0, 0);
      wb(8'h00, 1, 1);
      wait_freq(6000, 3000);
      check("ramp set time", (k + 1) * 100 * TICK, c, 20 * TICK);
      wb(8'h00, 0, 1);
      wait_freq(0, 3000);
    end
    $display("ramp sets done");
    term(0, 0, 0, 0, 0);
    for (int n = 1; n <= 15; n++) wb(8'h80 + 8'(4 * (n - 1)), preset[n], 1);
    term(0, 5, 15, 0, 0);
    wait_freq(preset[5], 400);
    check("presets without run", 0, out_freq_q, 0);
    wb(8'h00, 1, 1);
    for (int n = 0; n <= 16; n++) begin
      e = (n == 0 || n == 16) ? 6000 : preset[n];
      term(0, (n == 16) ? 15 : n, (n == 16) ? 0 : 15, 0, 0);
      wait_freq(e, 1000);
      check("preset reference", e, out_freq_q, 0);
    end
    term(0, 0, 0, 0, 0);
    $display("presets done");
    wb(8'h1c, 200, 1);
    wb(8'h60, 3000, 1);
    wb(8'h64, 4000, 1);
    wb(8'h68, 5000, 1);
    for (int i = 0; i < 5; i++) begin
      wb(8'h0c, tbl[i][0], 1);
      wait_freq(tbl[i][1], 1000);
      check("skip band edge", tbl[i][1], out_freq_q, 0);
    end
    wb(8'h1c, 0, 1);
    $display("skip bands done");
    wb(8'h0c, 4500, 1);
    wb(8'h28, 500, 1);
    for (int i = 0; i <= 2; i++) begin
      load <= 16'(500 * i);
      wait_freq(4500 - 250 * i, 1000);
      check("droop", 4500 - 250 * i, out_freq_q, 0);
    end
    load <= 16'h0000;
    wb(8'h28, 0, 1);
    wb(8'h00, 0, 1);
    wait_freq(0, 3000);
    $display("droop done");
    wb(8'h20, 1000, 1);
    wb(8'h24, 500, 1);
    wb(8'h0c, 2000, 1);
    analog <= 16'd1400;
    wb(8'h00, 8'h21, 1);
    wait_freq(2000, 400);
    check("held below start level", 0, out_freq_q, 0);
    analog <= 16'd1500;
    wait_freq(2000, 1000);
    check("start at upper level", 2000, out_freq_q, 0);
    check("running flag", 1, running_q, 0);
    analog <= 16'd1200;
    wait_freq(0, 400);
    check("keeps running above stop", 2000, out_freq_q, 0);
    analog <= 16'd1000;
    wait_freq(0, 1000);
    check("stops at threshold", 0, out_freq_q, 0);
    check("stopped flag", 0, running_q, 0);
    wb(8'h00, 0, 1);
    $display("hysteresis done");
    wb(8'h10, 1000, 1);
    wb(8'h14, 1, 1);
    wb(8'h18, 1, 1);
    wb(8'h00, 8'h40, 1);
    for (int s = 0; s < 3; s++) begin
      term(0, 0, 0, 0, 1 << s);
      wait_freq(1000, 1000);
      check("jog frequency", 1000, out_freq_q, 0);
      term(0, 0, 0, 0, 0);
      wait_freq(0, 1000);
      check("jog stop", 0, out_freq_q, 0);
    end
    $display("jog done");
    wb(8'h30, 1, 1);
    wb(8'h0c, 1200, 1);
    wb(8'h00, 1, 1);
    wait_freq(1200, 1000);
    term(0, 0, 0, 1, 0);
    wait_dir(1'b1, 3000);
    check("reverse", 1, out_reverse_q, 0);
    check("dead time", 100 * TICK, z, 10);
    wb(8'h00, 8'h03, 1);
    wait_dir(1'b0, 3000);
    check("reverse prohibited", 0, out_reverse_q, 0);
    wb(8'h00, 8'h1b, 1);
    wait_dir(1'b1, 3000);
    check("program direction", 1, out_reverse_q, 0);
    wb(8'h00, 8'h05, 1);
    wait_freq(1200, 1000);
    term(0, 0, 0, 0, 0);
    wait_dir(1'b0, 600);
    check("traverse holds direction", 1, out_reverse_q, 0);
    $display("direction done");
    close_out();
  end
endmodule
